/* File: hw/host_test_control_register.sv */
// Contract
// - Discard test bit 30 set: discard timer preloads 3ff0h.
// - Discard test bit clear: timer starts at zero, expires at 3fffh.
// - Boot ROM access time in PCI clocks from bits 27-24, default four.
// - Data RAM test uses bits 20-12 as data FIFO word address.
// - Bit 9 turns TX manager into read generator, RX into write generator.
// - Bus master test mode suppresses normal buffer manager operation.
// - Bit 7 opens receive data FIFO through receive_config at bits 20-12 while bit 5 is clear.
// - Bit 6 opens transmit data FIFO through transmit_config at bits 20-12.
// - Bit 5 opens receive status FIFO through receive_config at bits 4-0.
// - Status RAM test uses bits 4-0 as status FIFO entry address.
// - Bus master read test discards read data and may repeat cycles.
`timescale 1ns/10ps
`default_nettype none
`include "test_control_consts.svh"

module host_test_control_register (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output test_control_pkg::ram_req_t ram_req,
  input wire logic [31:0] ram_rdata,
  output test_control_pkg::bm_ctrl_t bm_ctrl,
  input wire logic dt_start,
  input wire logic dt_clear,
  output logic dt_expired,
  input wire logic rom_req,
  output logic rom_done
);

  localparam logic [31:0] TC_RESET = (`TC_HW_RESET & `TC_WRITABLE & ~`BOOT_FIELD_MASK)
                                   | (32'(`BOOT_DEFAULT) << `BOOT_LSB);

  test_control_pkg::state_t s;
  test_control_pkg::state_t next_s;
  test_control_pkg::ram_target_t wr_target;
  test_control_pkg::ram_target_t rd_target;
  logic accept;
  logic [3:0] boot_clocks;

  // Which FIFO a config register access reaches; status RAM wins over RX data RAM
  function automatic test_control_pkg::ram_target_t target_of(input logic [7:0] a, input logic [31:0] tc);
    if (a == `OFS_TRANSMIT_CONFIG && tc[`BIT_TX_RAM])
      target_of = test_control_pkg::RAM_TX_DATA;
    else if (a == `OFS_RECEIVE_CONFIG && tc[`BIT_ST_RAM])
      target_of = test_control_pkg::RAM_RX_STATUS;
    else if (a == `OFS_RECEIVE_CONFIG && tc[`BIT_RX_RAM])
      target_of = test_control_pkg::RAM_RX_DATA;
    else
      target_of = test_control_pkg::RAM_NONE;
  endfunction

  function automatic logic [8:0] ram_addr_of(input test_control_pkg::ram_target_t t, input logic [31:0] tc);
    if (t == test_control_pkg::RAM_RX_STATUS)
      ram_addr_of = {`SADDR_PAD, tc[`SADDR_MSB:`SADDR_LSB]};
    else
      ram_addr_of = tc[`DADDR_MSB:`DADDR_LSB];
  endfunction

  function automatic logic [31:0] read_value(input logic [7:0] a, input test_control_pkg::state_t st);
    if (a == `OFS_TEST_CONTROL)
      read_value = st.test_control;
    else if (a == `OFS_TRANSMIT_CONFIG)
      read_value = st.transmit_config;
    else if (a == `OFS_RECEIVE_CONFIG)
      read_value = st.receive_config;
    else
      read_value = 32'h0000_0000;
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.ram.we = 1'b0;
    next_s.ram.re = 1'b0;
    next_s.rom_done = 1'b0;
    accept = hsel && htrans[`HTRANS_ACTIVE_BIT] && hready;
    wr_target = target_of(s.addr, s.test_control);
    rd_target = test_control_pkg::RAM_NONE;
    boot_clocks = s.test_control[`BOOT_MSB:`BOOT_LSB];
    if (boot_clocks == `ROM_ZERO)
      boot_clocks = `BOOT_MIN;

    case (s.bus)
      test_control_pkg::BUS_IDLE, test_control_pkg::BUS_WRITE:
      begin
        if (s.bus == test_control_pkg::BUS_WRITE)
        begin
          if (s.addr == `OFS_TEST_CONTROL)
            next_s.test_control = hwdata & `TC_WRITABLE;
          else if (wr_target != test_control_pkg::RAM_NONE)
          begin
            next_s.ram.target = wr_target;
            next_s.ram.addr = ram_addr_of(wr_target, s.test_control);
            next_s.ram.wdata = hwdata;
            if (wr_target == test_control_pkg::RAM_RX_STATUS)
              next_s.ram.wdata = {`STATUS_PAD, hwdata[`STATUS_MSB:0]};
            next_s.ram.we = 1'b1;
          end
          else if (s.addr == `OFS_TRANSMIT_CONFIG)
            next_s.transmit_config = hwdata;
          else if (s.addr == `OFS_RECEIVE_CONFIG)
            next_s.receive_config = hwdata;
          next_s.bus = test_control_pkg::BUS_IDLE;
        end
        if (accept)
        begin
          next_s.addr = haddr[`ADDR_MSB:`ADDR_LSB];
          if (hwrite)
            next_s.bus = test_control_pkg::BUS_WRITE;
          else
          begin
            rd_target = target_of(haddr[`ADDR_MSB:`ADDR_LSB], next_s.test_control);
            if (rd_target != test_control_pkg::RAM_NONE)
            begin
              // FIFO reads stretch the data phase until the RAM answers
              next_s.ram.target = rd_target;
              next_s.ram.addr = ram_addr_of(rd_target, next_s.test_control);
              next_s.ram.re = 1'b1;
              next_s.hreadyout = 1'b0;
              next_s.bus = test_control_pkg::BUS_RAM_WAIT;
            end
            else
              next_s.hrdata = read_value(haddr[`ADDR_MSB:`ADDR_LSB], next_s);
          end
        end
      end
      test_control_pkg::BUS_RAM_WAIT:
        next_s.bus = test_control_pkg::BUS_RAM_CAPTURE;
      test_control_pkg::BUS_RAM_CAPTURE:
      begin
        next_s.hrdata = ram_rdata;
        if (s.ram.target == test_control_pkg::RAM_RX_STATUS)
          next_s.hrdata = {`STATUS_PAD, ram_rdata[`STATUS_MSB:0]};
        next_s.hreadyout = 1'b1;
        next_s.bus = test_control_pkg::BUS_IDLE;
      end
      default:
        next_s.bus = test_control_pkg::BUS_IDLE;
    endcase

    next_s.bm.tx_read_generator = next_s.test_control[`BIT_BM_TEST];
    next_s.bm.rx_write_generator = next_s.test_control[`BIT_BM_TEST];
    next_s.bm.normal_buffer_ops = !next_s.test_control[`BIT_BM_TEST];
    next_s.bm.read_data_sink = next_s.test_control[`BIT_BM_TEST];

    // Discard timer; a new start wins over a clear in the same cycle
    if (dt_start)
    begin
      next_s.dt_count = s.test_control[`BIT_DISCARD_TEST] ? `DT_TEST_PRELOAD : `DT_NORMAL_PRELOAD;
      next_s.dt_running = 1'b1;
      next_s.dt_expired = 1'b0;
    end
    else if (dt_clear)
    begin
      // An expiry in the same cycle as a clear still sets the flag
      next_s.dt_running = 1'b0;
      next_s.dt_expired = s.dt_running && s.dt_count == `DT_LIMIT;
    end
    else if (s.dt_running)
    begin
      if (s.dt_count == `DT_LIMIT)
      begin
        next_s.dt_expired = 1'b1;
        next_s.dt_running = 1'b0;
      end
      else
        next_s.dt_count = s.dt_count + `DT_STEP;
    end

    // Boot ROM access: rom_done pulses boot_clocks edges after the request edge
    if (rom_req && !s.rom_busy)
    begin
      next_s.rom_count = boot_clocks - `ROM_STEP;
      next_s.rom_busy = 1'b1;
    end
    else if (s.rom_busy)
    begin
      if (s.rom_count == `ROM_ZERO)
      begin
        next_s.rom_busy = 1'b0;
        next_s.rom_done = 1'b1;
      end
      else
        next_s.rom_count = s.rom_count - `ROM_STEP;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.bus <= test_control_pkg::BUS_IDLE;
      s.test_control <= TC_RESET;
      s.hreadyout <= 1'b1;
      s.hresp <= `HRESP_OKAY;
      s.ram.target <= test_control_pkg::RAM_NONE;
      s.bm.normal_buffer_ops <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign ram_req = s.ram;
  assign bm_ctrl = s.bm;
  assign dt_expired = s.dt_expired;
  assign rom_done = s.rom_done;

  property p_dt_test_preload;
    @(posedge hclk) disable iff (!hresetn)
    (dt_start && s.test_control[`BIT_DISCARD_TEST]) |=> (s.dt_count == 14'h3FF0 && s.dt_running);
  endproperty
  a_dt_test_preload: assert property (p_dt_test_preload) else $error("discard timer test preload wrong");

  property p_dt_normal_expire;
    @(posedge hclk) disable iff (!hresetn)
    (s.dt_running && s.dt_count == 14'h3FFF && !dt_start && !dt_clear) |=> (s.dt_expired && !s.dt_running);
  endproperty
  a_dt_normal_expire: assert property (p_dt_normal_expire) else $error("discard timer did not expire at limit");

  property p_dt_normal_start;
    @(posedge hclk) disable iff (!hresetn)
    (dt_start && !s.test_control[`BIT_DISCARD_TEST]) |=> (s.dt_count == 14'h0000 && !s.dt_expired);
  endproperty
  a_dt_normal_start: assert property (p_dt_normal_start) else $error("discard timer did not start at zero");

  property p_rom_four_clocks;
    @(posedge hclk) disable iff (!hresetn)
    (rom_req && !s.rom_busy && s.test_control[`BOOT_MSB:`BOOT_LSB] == 4'h4) |=> !rom_done [*4] ##1 rom_done;
  endproperty
  a_rom_four_clocks: assert property (p_rom_four_clocks) else $error("boot ROM access time not four clocks");

  property p_data_ram_addr;
    @(posedge hclk) disable iff (!hresetn)
    ((ram_req.we || ram_req.re) && ram_req.target != test_control_pkg::RAM_RX_STATUS)
      |-> ram_req.addr == $past(next_s.test_control[`DADDR_MSB:`DADDR_LSB]);
  endproperty
  a_data_ram_addr: assert property (p_data_ram_addr) else $error("data FIFO test address wrong");

  property p_bm_mode;
    @(posedge hclk) disable iff (!hresetn)
    bm_ctrl.tx_read_generator == s.test_control[`BIT_BM_TEST] && bm_ctrl.rx_write_generator == bm_ctrl.tx_read_generator;
  endproperty
  a_bm_mode: assert property (p_bm_mode) else $error("bus master generators do not follow enable");

  property p_bm_suppress;
    @(posedge hclk) disable iff (!hresetn)
    bm_ctrl.normal_buffer_ops != bm_ctrl.tx_read_generator && bm_ctrl.read_data_sink == bm_ctrl.tx_read_generator;
  endproperty
  a_bm_suppress: assert property (p_bm_suppress) else $error("normal buffer operation not suppressed");

  property p_rx_ram_write;
    @(posedge hclk) disable iff (!hresetn)
    (s.bus == test_control_pkg::BUS_WRITE && s.addr == `OFS_RECEIVE_CONFIG && s.test_control[`BIT_RX_RAM]
      && !s.test_control[`BIT_ST_RAM]) |=> (ram_req.we && ram_req.target == test_control_pkg::RAM_RX_DATA
      && ram_req.wdata == $past(hwdata) && s.receive_config == $past(s.receive_config));
  endproperty
  a_rx_ram_write: assert property (p_rx_ram_write) else $error("receive data FIFO write not issued");

  property p_tx_ram_read;
    @(posedge hclk) disable iff (!hresetn)
    (ram_req.re && ram_req.target == test_control_pkg::RAM_TX_DATA) |-> !hreadyout ##1 !hreadyout
      ##1 (hreadyout && hrdata == $past(ram_rdata));
  endproperty
  a_tx_ram_read: assert property (p_tx_ram_read) else $error("transmit data FIFO read not returned");

  property p_status_ram;
    @(posedge hclk) disable iff (!hresetn)
    ((ram_req.we || ram_req.re) && ram_req.target == test_control_pkg::RAM_RX_STATUS)
      |-> (ram_req.addr[8:5] == 4'h0 && ram_req.addr[4:0] == $past(next_s.test_control[`SADDR_MSB:`SADDR_LSB])
      && ram_req.wdata[31:23] == 9'h000);
  endproperty
  a_status_ram: assert property (p_status_ram) else $error("status FIFO access malformed");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    (s.test_control & ~`TC_WRITABLE) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved test_control bit set");

  property p_tc_write;
    @(posedge hclk) disable iff (!hresetn)
    (s.bus == test_control_pkg::BUS_WRITE && s.addr == `OFS_TEST_CONTROL)
      |=> (s.test_control[`BIT_DISCARD_TEST] == $past(hwdata[`BIT_DISCARD_TEST])
      && s.test_control[`BIT_BM_TEST] == $past(hwdata[`BIT_BM_TEST])
      && s.test_control[`BOOT_MSB:`BOOT_LSB] == $past(hwdata[`BOOT_MSB:`BOOT_LSB]));
  endproperty
  a_tc_write: assert property (p_tc_write) else $error("test_control write not stored");

  property p_tc_read;
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && haddr[`ADDR_MSB:`ADDR_LSB] == `OFS_TEST_CONTROL)
      |=> (hreadyout && (hrdata & ~`TC_WRITABLE) == 32'h0000_0000);
  endproperty
  a_tc_read: assert property (p_tc_read) else $error("reserved test_control bit read nonzero");

  property p_rom_min_one;
    @(posedge hclk) disable iff (!hresetn)
    (rom_req && !s.rom_busy && s.test_control[`BOOT_MSB:`BOOT_LSB] <= `BOOT_MIN) |=> !rom_done ##1 rom_done;
  endproperty
  a_rom_min_one: assert property (p_rom_min_one) else $error("boot ROM short access time wrong");

  property p_read_sink;
    @(posedge hclk) disable iff (!hresetn)
    bm_ctrl.read_data_sink == s.test_control[`BIT_BM_TEST];
  endproperty
  a_read_sink: assert property (p_read_sink) else $error("read data sink does not follow enable");

  property p_tx_ram_write;
    @(posedge hclk) disable iff (!hresetn)
    (s.bus == test_control_pkg::BUS_WRITE && s.addr == `OFS_TRANSMIT_CONFIG && s.test_control[`BIT_TX_RAM])
      |=> (ram_req.we && ram_req.target == test_control_pkg::RAM_TX_DATA && ram_req.wdata == $past(hwdata)
      && s.transmit_config == $past(s.transmit_config));
  endproperty
  a_tx_ram_write: assert property (p_tx_ram_write) else $error("transmit data FIFO write not issued");

  property p_status_write;
    @(posedge hclk) disable iff (!hresetn)
    (s.bus == test_control_pkg::BUS_WRITE && s.addr == `OFS_RECEIVE_CONFIG && s.test_control[`BIT_ST_RAM])
      |=> (ram_req.we && ram_req.target == test_control_pkg::RAM_RX_STATUS
      && s.receive_config == $past(s.receive_config));
  endproperty
  a_status_write: assert property (p_status_write) else $error("status FIFO write not issued");

  property p_rx_ram_read;
    @(posedge hclk) disable iff (!hresetn)
    (ram_req.re && ram_req.target == test_control_pkg::RAM_RX_DATA) |-> !hreadyout ##1 !hreadyout
      ##1 (hreadyout && hrdata == $past(ram_rdata));
  endproperty
  a_rx_ram_read: assert property (p_rx_ram_read) else $error("receive data FIFO read not returned");

  property p_dt_clear;
    @(posedge hclk) disable iff (!hresetn)
    (dt_clear && !dt_start && !(s.dt_running && s.dt_count == `DT_LIMIT)) |=> (!s.dt_running && !dt_expired);
  endproperty
  a_dt_clear: assert property (p_dt_clear) else $error("discard timer clear ignored");

endmodule
`default_nettype wire

/* File: hw/test_control_consts.svh */
`ifndef TEST_CONTROL_CONSTS_SVH
`define TEST_CONTROL_CONSTS_SVH

// Register byte offsets inside the decoded window
`define OFS_TEST_CONTROL 8'h0C
`define OFS_TRANSMIT_CONFIG 8'h20
`define OFS_RECEIVE_CONFIG 8'h30
`define ADDR_LSB 0
`define ADDR_MSB 7

// test_control layout
`define TC_HW_RESET 32'h0340_0000
`define TC_WRITABLE 32'h4F1F_F2FF
`define BOOT_FIELD_MASK 32'h0F00_0000
`define BIT_DISCARD_TEST 30
`define BOOT_MSB 27
`define BOOT_LSB 24
`define BOOT_DEFAULT 4'h4
`define BOOT_MIN 4'h1
`define DADDR_MSB 20
`define DADDR_LSB 12
`define BIT_BM_TEST 9
`define BIT_RX_RAM 7
`define BIT_TX_RAM 6
`define BIT_ST_RAM 5
`define SADDR_MSB 4
`define SADDR_LSB 0
`define SADDR_PAD 4'h0
`define STATUS_MSB 22
`define STATUS_PAD 9'h000

// Delayed-transaction discard timer and boot ROM access counter
`define DT_TEST_PRELOAD 14'h3FF0
`define DT_NORMAL_PRELOAD 14'h0000
`define DT_LIMIT 14'h3FFF
`define DT_STEP 14'h0001
`define ROM_STEP 4'h1
`define ROM_ZERO 4'h0

// AHB-Lite encodings
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'h0

`endif

/* File: hw/test_control_pkg.sv */
package test_control_pkg;

  typedef enum logic [1:0] {RAM_NONE, RAM_TX_DATA, RAM_RX_DATA, RAM_RX_STATUS} ram_target_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RAM_WAIT, BUS_RAM_CAPTURE} bus_state_t;

  typedef struct packed {
    ram_target_t target;
    logic [8:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } ram_req_t;

  typedef struct packed {
    logic tx_read_generator;
    logic rx_write_generator;
    logic normal_buffer_ops;
    logic read_data_sink;
  } bm_ctrl_t;

  typedef struct packed {
    bus_state_t bus;
    logic [7:0] addr;
    logic [31:0] test_control;
    logic [31:0] transmit_config;
    logic [31:0] receive_config;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    ram_req_t ram;
    bm_ctrl_t bm;
    logic [13:0] dt_count;
    logic dt_running;
    logic dt_expired;
    logic [3:0] rom_count;
    logic rom_busy;
    logic rom_done;
  } state_t;

endpackage

/* File: sim/fifo_model.sv */
`timescale 1ns/10ps
`default_nettype none

module fifo_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire test_control_pkg::ram_req_t ram_req,
  output logic [31:0] ram_rdata
);
  logic [31:0] mem [0:3][0:511];

  // Outside a read answer the data toggles every cycle, so a stale sample never matches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ram_rdata <= 32'h5A5A_A5A5;
    else if (ram_req.re)
      ram_rdata <= mem[ram_req.target][ram_req.addr];
    else
      ram_rdata <= ~ram_rdata;
  end

  always_ff @(posedge hclk)
  begin
    if (ram_req.we)
      mem[ram_req.target][ram_req.addr] <= ram_req.wdata;
  end
endmodule

`default_nettype wire

/* File: sim/test_host_test_control_register.sv */
`timescale 1ns/10ps
`default_nettype none
`include "test_control_consts.svh"

module test_host_test_control_register;
  typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic [3:0] bm;} row_t;
  typedef struct packed {logic [31:0] tc; logic [7:0] a; logic [1:0] tg; logic [8:0] ra; logic [31:0] wd;
    logic [31:0] rd;} frow_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic dt_start = 1'b0;
  logic dt_clear = 1'b0;
  logic rom_req = 1'b0;
  logic hreadyout, hresp, dt_expired, rom_done;
  logic [31:0] hrdata, ram_rdata, q;
  test_control_pkg::ram_req_t ram_req;
  test_control_pkg::bm_ctrl_t bm_ctrl;
  int num_errors = 0;
  int checks = 0;
  int n;
  logic [31:0] rst_val;
  logic [3:0] nv [4] = '{4'h4, 4'h1, 4'hF, 4'h0};
  row_t rows [7] = '{'{8'h0C, 32'hB0E0_0D00, 32'h0000_0000, 4'h2}, '{8'h20, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 4'h2},
    '{8'h30, 32'h1234_5678, 32'h1234_5678, 4'h2}, '{8'h84, 32'hFFFF_FFFF, 32'h0000_0000, 4'h2},
    '{8'h0C, 32'h0000_0200, 32'h0000_0200, 4'hD}, '{8'h0C, 32'h0F00_0000, 32'h0F00_0000, 4'h2},
    '{8'h20, 32'h0000_0001, 32'h0000_0001, 4'h2}};
  frow_t frows [5] = '{'{32'h001A_5040, 8'h20, 2'h1, 9'h1A5, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
    '{32'h001F_F040, 8'h20, 2'h1, 9'h1FF, 32'h0F0F_0F0F, 32'h0F0F_0F0F},
    '{32'h0005_A080, 8'h30, 2'h2, 9'h05A, 32'h1357_9BDF, 32'h1357_9BDF},
    '{32'h0000_0033, 8'h30, 2'h3, 9'h013, 32'hFFFF_FFFF, 32'h007F_FFFF},
    '{32'h000F_F0AA, 8'h30, 2'h3, 9'h00A, 32'h00AB_CDEF, 32'h002B_CDEF}};

  always #2 hclk = ~hclk;

  host_test_control_register i_host_test_control_register (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ram_req(ram_req), .ram_rdata(ram_rdata), .bm_ctrl(bm_ctrl), .dt_start(dt_start),
    .dt_clear(dt_clear), .dt_expired(dt_expired), .rom_req(rom_req), .rom_done(rom_done)
  );

  fifo_model i_fifo_model (.hclk(hclk), .hresetn(hresetn), .ram_req(ram_req), .ram_rdata(ram_rdata));

  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    check32({31'h0, hresp}, {31'h0, `HRESP_OKAY}, "hresp");
    if (k >= 100 || n >= 100)
    begin
      num_errors++;
      $display("MISMATCH %0t bus hang", $time);
      complete_run();
    end
  endtask

  task automatic wait_flag(ref logic f, input int bound);
    n = 0;
    do begin @(posedge hclk); #1; n++; end while (f !== 1'b1 && n < bound);
    if (f !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH %0t wait timeout", $time);
      complete_run();
    end
  endtask

  task automatic dt_run(input int exp);
    @(posedge hclk);
    dt_start <= 1'b1;
    @(posedge hclk);
    dt_start <= 1'b0;
    wait_flag(dt_expired, 20000);
    check32(n, exp, "discard edges");
    repeat (3) @(posedge hclk);
    check32({31'h0, dt_expired}, 32'h1, "expired sticky");
    dt_clear <= 1'b1;
    @(posedge hclk);
    dt_clear <= 1'b0;
    #1;
    check32({31'h0, dt_expired}, 32'h0, "expired clear");
  endtask

  initial
  begin
    // A real falling edge, so the asynchronous reset branches run
    hresetn <= 1'b0;
    rst_val = (`TC_HW_RESET & `TC_WRITABLE & ~`BOOT_FIELD_MASK) | {4'h0, `BOOT_DEFAULT, 24'h0};
    repeat (16) @(posedge hclk);
    check32({hreadyout, dt_expired, rom_done, bm_ctrl, ram_req.we, ram_req.re}, 32'h108, "reset outs");
    hresetn <= 1'b1;
    bus(1'b0, 8'h0C, 32'h0, q);
    check32(q, rst_val, "reset value");
    // buffer managers run in normal operation around every bus master test toggle
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, rows[i].a, rows[i].wd, q);
      bus(1'b0, rows[i].a, 32'h0, q);
      check32(q, rows[i].rd, "reg read");
      check32({28'h0, bm_ctrl}, {28'h0, rows[i].bm}, "bm_ctrl");
    end
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, 8'h0C, frows[i].tc, q);
      bus(1'b1, frows[i].a, frows[i].wd, q);
      bus(1'b0, frows[i].a, 32'h0, q);
      check32(n, 3, "fifo wait");
      check32(q, frows[i].rd, "fifo data");
      check32({21'h0, ram_req.target, ram_req.addr}, {21'h0, frows[i].tg, frows[i].ra}, "fifo sel");
    end
    bus(1'b1, 8'h0C, 32'h0, q);
    bus(1'b0, 8'h20, 32'h0, q);
    check32(q, 32'h0000_0001, "tx cfg kept");
    check32(n, 1, "plain wait");
    bus(1'b0, 8'h30, 32'h0, q);
    check32(q, 32'h1234_5678, "rx cfg kept");
    bus(1'b1, 8'h0C, 32'h4000_0000, q);
    dt_run(int'(14'h3FFF - 14'h3FF0) + 1);
    bus(1'b1, 8'h0C, 32'h0, q);
    dt_run(int'(14'h3FFF) + 1);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h0C, {4'h0, nv[i], 24'h0}, q);
      @(posedge hclk);
      rom_req <= 1'b1;
      @(posedge hclk);
      rom_req <= 1'b0;
      wait_flag(rom_done, 40);
      check32(n, (nv[i] == 4'h0) ? 1 : int'(nv[i]), "rom clocks");
      @(posedge hclk);
      #1;
      check32({31'h0, rom_done}, 32'h0, "rom pulse");
    end
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h0C, 32'h0, q);
    check32(q, rst_val, "second reset");
    complete_run();
  end
endmodule

`default_nettype wire
